// >>> bench/acq_ctrl_asserts.sv
`timescale 1ns/1ps
module acq_ctrl_asserts (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Channel and converter side
	input wire logic [3:0] channel_select,
	input wire logic scan_disable_n,
	input wire logic [3:0] mux_channel,
	input wire logic [1:0] input_range_code,
	input wire logic convert_start,
	input wire logic calibrate_start,
	input wire logic conversion_active
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	range_reset_a: assert property (
		$fell(rst) |-> input_range_code == 2'h2) else $error("range reset");
	range_write_a: assert property (
		reg_wr && reg_addr == 3'h5 |=> input_range_code == $past(reg_wdata[1:0]))
		else $error("range write");
	range_read_a: assert property (
		reg_rd && reg_addr == 3'h5 |=> reg_rdata == 8'h00)
		else $error("range read");
	idle_rdata_a: assert property (
		!reg_rd |=> reg_rdata == 8'h00) else $error("idle read data");
	status_read_a: assert property (
		reg_rd && reg_addr == 3'h0 |=> reg_rdata[4] == $past(conversion_active))
		else $error("status busy bit");
	cal_active_a: assert property (
		calibrate_start |=> conversion_active [*8]) else $error("calibration busy");
	conv_active_a: assert property (
		convert_start |=> conversion_active [*4]) else $error("conversion busy");
	single_chan_a: assert property (
		scan_disable_n |=> mux_channel == $past(channel_select))
		else $error("single channel");
endmodule

bind adc_scan_cal_control acq_ctrl_asserts u_chk (.clk_sys, .rst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .channel_select, .scan_disable_n,
	.mux_channel, .input_range_code, .convert_start, .calibrate_start,
	.conversion_active);

// >>> bench/adc_model.sv
`timescale 1ns/1ps
// The converter latches the multiplexer address when a conversion starts.
module adc_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control from the block
	input wire logic convert_start,
	input wire logic [3:0] mux_channel,
	// Observation
	output logic [3:0] seen,
	output logic [7:0] n
);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			n <= 8'h00;
		end else if (convert_start) begin
			seen <= mux_channel;
			n <= n + 8'h01;
		end
	end
endmodule

// >>> bench/tb_adc_scan_cal_control.sv
`timescale 1ns/1ps
module tb_adc_scan_cal_control;
	logic clk_sys = 0;
	logic rst = 1;
	logic wr = 0;
	logic rd = 0;
	logic sdn = 1;
	logic c0_n = 1;
	logic ex_n = 1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wd = 8'h00;
	logic [7:0] rdat;
	logic [7:0] v;
	logic [7:0] n;
	logic [7:0] n0;
	logic [3:0] ch = 4'h0;
	logic [3:0] mux;
	logic [3:0] seen;
	logic [1:0] rng;
	logic cs;
	logic ks;
	logic act;
	int fails = 0;
	int checks = 0;
	int cyc = 0;
	adc_scan_cal_control #(.cal_cycles(20), .conv_cycles(4)) u_dut (
		.clk_sys, .rst, .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(rdat), .channel_select(ch),
		.scan_disable_n(sdn), .counter0_convert_pulse_n(c0_n),
		.external_convert_strobe_n(ex_n), .mux_channel(mux),
		.input_range_code(rng), .convert_start(cs), .calibrate_start(ks),
		.conversion_active(act));
	adc_model u_adc (.clk_sys, .rst, .convert_start(cs), .mux_channel(mux),
		.seen, .n);
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	// The whole run needs well under a thousand cycles.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			give_verdict();
		end
	end
	// ----
	// Bus tasks
	// ----
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wd <= d;
		wr <= 1;
		@(posedge clk_sys);
		wr <= 0;
	endtask
	task rd_reg(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1;
		@(posedge clk_sys);
		rd <= 0;
		#1 v = rdat;
		chk(v, exp);
	endtask
	task trig(input logic e);
		@(posedge clk_sys);
		if (e) ex_n <= 0;
		else c0_n <= 0;
		repeat (5) @(posedge clk_sys);
		ex_n <= 1;
		c0_n <= 1;
		repeat (8) @(posedge clk_sys);
	endtask
	// ----
	// Scenarios
	// ----
	task t_reset();
		chk(8'(rng), 8'h02);
		chk(8'(mux), 8'h00);
		rd_reg(3'h7, 8'h00);
		rd_reg(3'h0, 8'h80);
	endtask
	task t_range();
		logic [1:0] codes [3];
		codes = '{2'h0, 2'h2, 2'h3};
		foreach (codes[i]) begin
			wr_reg(3'h5, 8'(codes[i]));
			#1 chk(8'(rng), 8'(codes[i]));
			rd_reg(3'h5, 8'h00);
		end
		wr_reg(3'h0, 8'hff);
		rd_reg(3'h0, 8'h80);
		rd_reg(3'h3, 8'h00);
	endtask
	task t_single();
		for (int i = 4; i < 16; i++) begin
			ch <= 4'(i);
			repeat (2) @(posedge clk_sys);
			chk(8'(mux), 8'(i));
		end
		ch <= 4'h9;
		n0 = n;
		trig(0);
		trig(1);
		chk(8'(seen), 8'h09);
		chk(n, n0 + 8'h02);
		wr_reg(3'h7, 8'h02);
		trig(0);
		trig(1);
		chk(n, n0 + 8'h02);
	endtask
	task t_scan(input logic dir);
		sdn <= 0;
		ch <= 4'h2;
		wr_reg(3'h7, {5'h00, dir, 2'h0});
		for (int k = 0; k < 3; k++) begin
			trig(0);
			chk(8'(seen), dir ? 8'(k) : 8'(2 - k));
		end
	endtask
	task t_cal();
		wr_reg(3'h7, 8'h01);
		rd_reg(3'h7, 8'h01);
		chk(8'(act), 8'h01);
		rd_reg(3'h0, 8'h90);
		repeat (25) @(posedge clk_sys);
		rd_reg(3'h0, 8'h80);
		wr_reg(3'h7, 8'h00);
	endtask
	task give_verdict();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		@(posedge clk_sys);
		#1 t_reset();
		t_range();
		t_single();
		t_scan(0);
		t_scan(1);
		t_cal();
		give_verdict();
	end
endmodule

// >>> hw/acq_defs.svh
`ifndef ACQ_DEFS_SVH
`define ACQ_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFF_STATUS 3'h0
`define OFF_RANGE 3'h5
`define OFF_SCANCAL 3'h7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_CALIBRATION_ENABLE 0
`define BIT_INHIBIT 1
`define BIT_DIR 2
`define BIT_CONV_ACTIVE 4
`define BIT_REVISION 7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CHANNEL 4'h0
`define RST_RANGE 2'h2
`define RST_SCANCAL 3'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CAL_TIME_US 10000
`define CLK_MHZ 10
`define CAL_CYCLES (`CAL_TIME_US * `CLK_MHZ)
`define CONV_CYCLES 100

`endif

// >>> hw/acq_pkg.sv
package acq_pkg;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic scan_disable_n;
		logic [3:0] channel_select;
	} chan_cfg_t;

	typedef enum logic [1:0] {
		range_0_10v = 2'h0,
		range_5v = 2'h2,
		range_2p5v = 2'h3
	} range_t;

	typedef enum {
		st_idle,
		st_convert,
		st_calibrate
	} seq_state_t;
endpackage

// >>> hw/adc_scan_cal_control.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "acq_defs.svh"

// How it works
// - Four-bit channel select picks one of 16 inputs; resets to zero.
// - Channel codes 4 through 15 drive the multiplexer as binary numbers.
// - Scan enabled: every channel between selected and zero is sampled.
// - Direction bit clear scans down to zero; set scans up from zero.
// - Scan disabled: only the selected channel is sampled throughout.
// - Inhibit resets clear; when set both trigger sources are blocked.
// - Calibration enable resets clear and permits converter calibration.
// - Write enable then read the control register to start calibration.
// - Conversion active status is high during conversion or calibration.
// - Two-bit range code resets to 10; codes 00, 10, 11 valid.
module adc_scan_cal_control #(
	parameter int cal_cycles = `CAL_CYCLES,
	parameter int conv_cycles = `CONV_CYCLES,
	// The revision bit value is arbitrary; a board ties it as it needs.
	parameter logic revision_id = 1'b1
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Channel configuration from the first command register
	input wire logic [3:0] channel_select,
	input wire logic scan_disable_n,
	// Trigger sources, active low pins
	input wire logic counter0_convert_pulse_n,
	input wire logic external_convert_strobe_n,
	// Converter side
	output logic [3:0] mux_channel,
	output logic [1:0] input_range_code,
	output logic convert_start,
	output logic calibrate_start,
	output logic conversion_active
);
	acq_pkg::reg_req_t req;
	acq_pkg::chan_cfg_t cfg;
	acq_pkg::seq_state_t state_q;
	acq_pkg::seq_state_t state_d;

	// Register state.
	logic [2:0] scancal_q;
	logic [2:0] scancal_d;
	logic [1:0] range_q;
	logic [1:0] range_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic cal_armed_q;
	logic cal_armed_d;
	logic restart_q;

	// Sequencer state.
	logic [31:0] count_q;
	logic [31:0] count_d;

	// Trigger pin synchronisers.
	logic [2:0] cnt0_sync_q;
	logic [2:0] ext_sync_q;
	logic cnt0_level_q;
	logic ext_level_q;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// True when a strobe addresses the given register.
	function automatic logic addr_hit(input logic strobe,
		input logic [2:0] addr, input logic [2:0] offset);
		return strobe && addr == offset;
	endfunction

	// A pin counts as low once the last two stages agree on zero.
	function automatic logic settled_low(input logic [2:0] sync);
		return sync[2] == 1'b0 && sync[1] == 1'b0;
	endfunction

	// The level follows the pin only after two agreeing samples, which
	// filters a one-sample glitch on the connector.
	function automatic logic next_level(input logic level,
		input logic [2:0] sync);
		logic agree;
		agree = sync[2] == sync[1];
		return agree ? sync[2] : level;
	endfunction

	// Loads the down counter so that a busy phase lasts n cycles.
	function automatic logic [31:0] load_count(input int n);
		return 32'(n - 1);
	endfunction

	// True while the sequencer waits for work.
	function automatic logic is_idle(input acq_pkg::seq_state_t st);
		return st == acq_pkg::st_idle;
	endfunction

	// Builds the status byte; the other bits are always zero.
	function automatic logic [7:0] pack_status(input logic rev,
		input logic busy);
		logic [7:0] word;
		word = 8'h00;
		word[`BIT_REVISION] = rev;
		word[`BIT_CONV_ACTIVE] = busy;
		return word;
	endfunction

	// ------------------------------------------------------------------
	// Bus bundle
	// ------------------------------------------------------------------
	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr,
		rd: reg_rd};
	assign cfg = '{scan_disable_n: scan_disable_n,
		channel_select: channel_select};

	// ------------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------------
	wire wr_scancal = addr_hit(req.wr, req.addr, `OFF_SCANCAL);
	wire wr_range = addr_hit(req.wr, req.addr, `OFF_RANGE);
	wire rd_scancal = addr_hit(req.rd, req.addr, `OFF_SCANCAL);
	wire rd_status = addr_hit(req.rd, req.addr, `OFF_STATUS);
	wire calibration_enable = scancal_q[`BIT_CALIBRATION_ENABLE];
	wire inhibit = scancal_q[`BIT_INHIBIT];
	wire scan_direction = scancal_q[`BIT_DIR];

	// The status address has no write path, so writes there are lost.
	wire [7:0] status_word = pack_status(revision_id, conversion_active);
	wire [7:0] scancal_word = {5'h0, scancal_q};
	// Unmapped and write-only addresses read back as zero.
	assign rdata_d = rd_status ? status_word
		: rd_scancal ? scancal_word : 8'h00;

	// Reserved bits are dropped, so stray ones cannot take effect.
	assign scancal_d = wr_scancal ? req.wdata[2:0] : scancal_q;
	// Code 01 is kept as written; the converter decides what it means.
	assign range_d = wr_range ? req.wdata[1:0] : range_q;

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scancal_q <= `RST_SCANCAL;
		end else begin
			scancal_q <= scancal_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			range_q <= `RST_RANGE;
		end else begin
			range_q <= range_d;
		end
	end

	// Read data are reloaded every cycle, so they stand for one cycle.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// A direction bit lands on the same edge as its write, so the scan
	// restart is applied one cycle later, when the new bit is visible.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			restart_q <= 1'b0;
		end else begin
			restart_q <= wr_scancal;
		end
	end

	assign reg_rdata = rdata_q;
	assign input_range_code = range_q;

	// ------------------------------------------------------------------
	// Trigger pin synchronisers
	// ------------------------------------------------------------------
	// Stages reset to the idle high level, so the release of reset is
	// never taken for a falling edge.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt0_sync_q <= 3'h7;
		end else begin
			cnt0_sync_q <= {cnt0_sync_q[1:0],
				counter0_convert_pulse_n};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ext_sync_q <= 3'h7;
		end else begin
			ext_sync_q <= {ext_sync_q[1:0],
				external_convert_strobe_n};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt0_level_q <= 1'b1;
		end else begin
			cnt0_level_q <= next_level(cnt0_level_q, cnt0_sync_q);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ext_level_q <= 1'b1;
		end else begin
			ext_level_q <= next_level(ext_level_q, ext_sync_q);
		end
	end

	wire cnt0_fall = cnt0_level_q && settled_low(cnt0_sync_q);
	wire ext_fall = ext_level_q && settled_low(ext_sync_q);
	wire pin_fall = cnt0_fall || ext_fall;
	// Calibration mode also holds off triggers, since conversion with
	// the enable still set is not allowed. A trigger that arrives while
	// the sequencer is busy is dropped, not queued.
	wire trigger = pin_fall && !inhibit && !calibration_enable;

	// ------------------------------------------------------------------
	// Calibration arming
	// ------------------------------------------------------------------
	// The dummy read after setting the enable is what launches the run.
	// Arming is spent by that launch, so a later read does not rerun it.
	wire cal_go = rd_scancal && calibration_enable && cal_armed_q;

	always_comb begin
		cal_armed_d = cal_armed_q;
		if (wr_scancal) begin
			cal_armed_d = req.wdata[`BIT_CALIBRATION_ENABLE];
		end else if (!calibration_enable || cal_go) begin
			cal_armed_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cal_armed_q <= 1'b0;
		end else begin
			cal_armed_q <= cal_armed_d;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	// A conversion and a calibration share one down counter; it is wide
	// enough for the full calibration time at the board clock.
	always_comb begin
		state_d = state_q;
		count_d = count_q;
		case (state_q)
			acq_pkg::st_idle: begin
				if (cal_go) begin
					state_d = acq_pkg::st_calibrate;
					count_d = load_count(cal_cycles);
				end else if (trigger) begin
					state_d = acq_pkg::st_convert;
					count_d = load_count(conv_cycles);
				end
			end
			acq_pkg::st_convert, acq_pkg::st_calibrate: begin
				if (count_q == 32'h0) begin
					state_d = acq_pkg::st_idle;
				end else begin
					count_d = count_q - 32'h1;
				end
			end
			default: begin
				state_d = acq_pkg::st_idle;
				count_d = 32'h0;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= acq_pkg::st_idle;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count_q <= 32'h0;
		end else begin
			count_q <= count_d;
		end
	end

	// ------------------------------------------------------------------
	// Converter outputs
	// ------------------------------------------------------------------
	wire seq_idle = is_idle(state_q);
	assign conversion_active = !is_idle(state_q);
	// Calibration start wins over a trigger in the same cycle.
	assign convert_start = seq_idle && trigger && !cal_go;
	assign calibrate_start = seq_idle && cal_go;
	wire conv_done = state_q == acq_pkg::st_convert && count_q == 32'h0;

	// ------------------------------------------------------------------
	// Channel stepping
	// ------------------------------------------------------------------
	// Any write to the control register restarts the scan from its first
	// channel so a new direction takes effect cleanly.
	scan_sequencer u_seq (
		.clk_sys(clk_sys),
		.rst(rst),
		.cfg(cfg),
		.scan_direction(scan_direction),
		.restart(restart_q),
		.step(conv_done),
		.mux_channel(mux_channel)
	);
endmodule

// >>> hw/scan_sequencer.sv
`timescale 1ns/1ps
`include "acq_defs.svh"

// Steps the multiplexer address after each finished conversion while scanning; with scan disabled it follows the channel select.
module scan_sequencer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Configuration
	input wire acq_pkg::chan_cfg_t cfg,
	input wire logic scan_direction,
	input wire logic restart,
	input wire logic step,
	// Multiplexer
	output logic [3:0] mux_channel
);
	logic [3:0] chan_q;
	logic [3:0] chan_d;
	logic [3:0] start_ch;
	logic at_end;

	// ------------------------------------------------------------------
	// Start point and wrap
	// ------------------------------------------------------------------
	assign start_ch = scan_direction ? 4'h0 : cfg.channel_select;
	assign at_end = scan_direction ? (chan_q == cfg.channel_select)
		: (chan_q == 4'h0);

	always_comb begin
		chan_d = chan_q;
		if (cfg.scan_disable_n) begin
			chan_d = cfg.channel_select;
		end else if (restart) begin
			chan_d = start_ch;
		end else if (step) begin
			if (at_end) begin
				chan_d = start_ch;
			end else if (scan_direction) begin
				chan_d = chan_q + 4'h1;
			end else begin
				chan_d = chan_q - 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			chan_q <= `RST_CHANNEL;
		end else begin
			chan_q <= chan_d;
		end
	end

	// Binary code drives the multiplexer directly.
	assign mux_channel = chan_q;
endmodule
